// ===== rtl/ptpi_pkg.sv
// package: register map, field positions, reset values and counts of the period timer
// assumes: 32-bit AHB-Lite register bus, single system clock of 25 MHz
package ptpi_pkg;
  // byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PERIOD = 8'h04;
  localparam logic [7:0] OFS_COUNT = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h10;
  localparam logic [7:0] OFS_IRQ_EN = 8'h14;
  // control field positions
  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_SRC_BIT = 1;
  localparam int CTRL_PRE_LSB = 4;
  localparam int CTRL_POST_LSB = 8;
  localparam int CTRL_MODE_LSB = 16;
  // status bit positions
  localparam int STAT_FLAG_BIT = 0;
  localparam int STAT_RUN_BIT = 1;
  localparam int STAT_ERS_BIT = 2;
  // widths
  localparam int CNT_W = 8;
  localparam int PRE_W = 3;
  localparam int POST_W = 4;
  localparam int MODE_W = 5;
  // reset values
  localparam logic [CNT_W-1:0] PERIOD_RST = 8'hFF;
  localparam logic [MODE_W-1:0] MODE_SW_GATE = 5'h00;
  // instruction clock is the system clock divided by four
  localparam int INSTR_DIV = 4;
  localparam logic [1:0] INSTR_LAST = 2'(INSTR_DIV - 1);
endpackage : ptpi_pkg

// ===== rtl/ptpi_sync3.sv
// three-flop synchroniser with agreement filter for one pin
// assumes: input is asynchronous to i_clk_sys
`timescale 1ns/10ps
module ptpi_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // pin and its filtered level
  input wire logic i_async,
  output logic o_level
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // a change counts only once stages two and three agree
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_level <= RST_VAL;
    end else if (s2_reg == s3_reg) begin
      o_level <= s3_reg;
    end
  end
endmodule : ptpi_sync3

// ===== rtl/ptpi_timer.sv
// period timer with prescaler, postscaler and interrupt, software-gated mode
// assumes: AHB-Lite single word transfers; timer clock and external reset arrive on pins
//
// Functional notes
// RULE1: mode value zero is software gate; only the run bit controls counting.
// RULE2: count advances per timer clock while run set, holds while clear.
// RULE3: count equal to period loads zero on next timer clock, keeps counting.
// RULE4: each match advances postscaler; flag raised when ratio 1:1..1:16 reached.
// RULE5: interrupt request forwarded only while timer interrupt enable set.
// RULE6: prescale and postscale select zero give 1:1 at both scalers.
// RULE7: non-instruction clock: run and external reset pass two timer clock stages.
// RULE8: instruction clock: external reset one period, run applies next period.
// RULE9: flag setting may lag the postscaled event by a couple of cycles.
// RULE10: run bit writes are synchronised into the timer clock before use.
// RULE11: postscaler returns to zero on event; flag stays until software clears.
//
// Added by the designer: the address map and the AHB-Lite slave port.
`timescale 1ns/10ps
module ptpi_timer (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // ahb-lite slave
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // timer pins
  input wire logic i_timer_clock_input,
  input wire logic i_ext_reset_signal,
  // events
  output logic o_postscaled_event,
  output logic o_irq
);
  // software state
  logic run_reg;
  logic clk_src_reg;
  logic [ptpi_pkg::PRE_W-1:0] prescale_select_reg;
  logic [ptpi_pkg::POST_W-1:0] postscale_select_reg;
  logic [ptpi_pkg::MODE_W-1:0] mode_reg;
  logic [ptpi_pkg::CNT_W-1:0] period_value_reg;
  logic timer_irq_enable_reg;
  logic timer_irq_flag_reg;
  // bus data phase
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  // timer clock domain emulation
  logic pin_clk_lvl;
  logic pin_clk_prev_reg;
  logic ers_lvl;
  logic [1:0] instr_div_reg;
  logic instr_en;
  logic tick;
  logic run_s1_reg;
  logic run_sync_reg;
  logic ers_s1_reg;
  logic ers_sync_reg;
  logic [6:0] pre_cnt_reg;
  logic pre_done;
  logic adv;
  logic match;
  logic [ptpi_pkg::CNT_W-1:0] count_value_reg;
  logic [ptpi_pkg::POST_W-1:0] post_cnt_reg;
  logic flag_set;
  logic flag_clr;

  // pin synchronisers
  ptpi_sync3 #(.RST_VAL(1'b0)) u_sync_clk (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_async(i_timer_clock_input),
    .o_level(pin_clk_lvl)
  );

  ptpi_sync3 #(.RST_VAL(1'b0)) u_sync_ers (
    .i_clk_sys(i_clk_sys),
    .i_rst_n(i_rst_n),
    .i_async(i_ext_reset_signal),
    .o_level(ers_lvl)
  );

  // bus: zero wait states, always okay
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end else if (i_hready) begin
      wr_pend_reg <= i_hsel && i_htrans[1] && i_hwrite;
      wr_addr_reg <= i_haddr[7:0];
    end
  end

  // read data latched at the address phase; unmapped reads give zero
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_hrdata <= 32'h0000_0000;
    end else if (i_hready && i_hsel && i_htrans[1] && !i_hwrite) begin
      o_hrdata <= 32'h0000_0000;
      case (i_haddr[7:0])
        ptpi_pkg::OFS_CTRL: begin
          o_hrdata[ptpi_pkg::CTRL_RUN_BIT] <= run_reg;
          o_hrdata[ptpi_pkg::CTRL_SRC_BIT] <= clk_src_reg;
          o_hrdata[ptpi_pkg::CTRL_PRE_LSB +: ptpi_pkg::PRE_W] <= prescale_select_reg;
          o_hrdata[ptpi_pkg::CTRL_POST_LSB +: ptpi_pkg::POST_W] <= postscale_select_reg;
          o_hrdata[ptpi_pkg::CTRL_MODE_LSB +: ptpi_pkg::MODE_W] <= mode_reg;
        end
        ptpi_pkg::OFS_PERIOD: o_hrdata[ptpi_pkg::CNT_W-1:0] <= period_value_reg;
        ptpi_pkg::OFS_COUNT: o_hrdata[ptpi_pkg::CNT_W-1:0] <= count_value_reg;
        ptpi_pkg::OFS_STATUS: begin
          o_hrdata[ptpi_pkg::STAT_FLAG_BIT] <= timer_irq_flag_reg;
          o_hrdata[ptpi_pkg::STAT_RUN_BIT] <= run_sync_reg;
          o_hrdata[ptpi_pkg::STAT_ERS_BIT] <= ers_sync_reg;
        end
        ptpi_pkg::OFS_IRQ_EN: o_hrdata[0] <= timer_irq_enable_reg;
        default: o_hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // control, period and irq enable registers, written in the data phase
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      run_reg <= 1'b0;
      clk_src_reg <= 1'b0;
      prescale_select_reg <= '0;
      postscale_select_reg <= '0;
      mode_reg <= ptpi_pkg::MODE_SW_GATE;
      period_value_reg <= ptpi_pkg::PERIOD_RST;
      timer_irq_enable_reg <= 1'b0;
    end else if (wr_pend_reg) begin
      case (wr_addr_reg)
        ptpi_pkg::OFS_CTRL: begin
          run_reg <= i_hwdata[ptpi_pkg::CTRL_RUN_BIT];
          clk_src_reg <= i_hwdata[ptpi_pkg::CTRL_SRC_BIT];
          prescale_select_reg <= i_hwdata[ptpi_pkg::CTRL_PRE_LSB +: ptpi_pkg::PRE_W];
          postscale_select_reg <= i_hwdata[ptpi_pkg::CTRL_POST_LSB +: ptpi_pkg::POST_W];
          mode_reg <= i_hwdata[ptpi_pkg::CTRL_MODE_LSB +: ptpi_pkg::MODE_W];
        end
        ptpi_pkg::OFS_PERIOD: period_value_reg <= i_hwdata[ptpi_pkg::CNT_W-1:0];
        ptpi_pkg::OFS_IRQ_EN: timer_irq_enable_reg <= i_hwdata[0];
        default: ;
      endcase
    end
  end

  // instruction clock enable from divider
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      instr_div_reg <= 2'h0;
    end else if (instr_div_reg == ptpi_pkg::INSTR_LAST) begin
      instr_div_reg <= 2'h0;
    end else begin
      instr_div_reg <= instr_div_reg + 2'h1;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pin_clk_prev_reg <= 1'b0;
    end else begin
      pin_clk_prev_reg <= pin_clk_lvl;
    end
  end

  assign instr_en = (instr_div_reg == ptpi_pkg::INSTR_LAST);
  assign tick = clk_src_reg ? instr_en : (pin_clk_lvl && !pin_clk_prev_reg);

  // run and ers retimed on timer clock edges
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      run_s1_reg <= 1'b0;
      run_sync_reg <= 1'b0;
      ers_s1_reg <= 1'b0;
      ers_sync_reg <= 1'b0;
    end else if (tick) begin
      run_s1_reg <= run_reg; // RULE10
      ers_s1_reg <= ers_lvl;
      if (clk_src_reg) begin
        run_sync_reg <= run_reg; // RULE8
        ers_sync_reg <= ers_lvl; // RULE8
      end else begin
        run_sync_reg <= run_s1_reg; // RULE7
        ers_sync_reg <= ers_s1_reg; // RULE7
      end
    end
  end

  // prescaler: ratio is two to the power of the select
  assign pre_done = ((pre_cnt_reg & 7'((8'h01 << prescale_select_reg) - 8'h01)) ==
                     7'((8'h01 << prescale_select_reg) - 8'h01)); // RULE6
  assign adv = tick && run_sync_reg && (mode_reg == ptpi_pkg::MODE_SW_GATE) && pre_done; // RULE1 RULE2
  assign match = adv && (count_value_reg == period_value_reg);

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      pre_cnt_reg <= 7'h00;
    end else if (tick && run_sync_reg && (mode_reg == ptpi_pkg::MODE_SW_GATE)) begin
      pre_cnt_reg <= pre_done ? 7'h00 : pre_cnt_reg + 7'h01;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      count_value_reg <= '0;
    end else if (match) begin
      count_value_reg <= '0; // RULE3
    end else if (adv) begin
      count_value_reg <= count_value_reg + 8'h01; // RULE2
    end
  end

  // postscaler: ratio is select plus one
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      post_cnt_reg <= '0;
      o_postscaled_event <= 1'b0;
    end else begin
      o_postscaled_event <= 1'b0;
      if (match) begin
        if (post_cnt_reg == postscale_select_reg) begin
          post_cnt_reg <= '0; // RULE11
          o_postscaled_event <= 1'b1; // RULE4
        end else begin
          post_cnt_reg <= post_cnt_reg + 4'h1; // RULE4
        end
      end
    end
  end

  // one extra stage stands for the cpu-side retiming
  assign flag_set = o_postscaled_event; // RULE9
  assign flag_clr = wr_pend_reg && (wr_addr_reg == ptpi_pkg::OFS_IRQ_CLR) &&
                    i_hwdata[ptpi_pkg::STAT_FLAG_BIT];

  // set wins over a simultaneous clear
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      timer_irq_flag_reg <= 1'b0;
    end else if (flag_set) begin
      timer_irq_flag_reg <= 1'b1; // RULE4
    end else if (flag_clr) begin
      timer_irq_flag_reg <= 1'b0; // RULE11
    end
  end

  // registered output costs one cycle of latency
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= timer_irq_flag_reg && timer_irq_enable_reg; // RULE5
    end
  end

  // checks
  sequence post_evt_s;
    o_postscaled_event ##1 timer_irq_flag_reg;
  endsequence

  sequence last_match_s;
    match && (post_cnt_reg == postscale_select_reg);
  endsequence

  mode_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE1
    (mode_reg != ptpi_pkg::MODE_SW_GATE) |=> $stable(count_value_reg))
    else $error("count moved outside software gate mode");

  stop_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE2
    !run_sync_reg |=> $stable(count_value_reg))
    else $error("count moved while stopped");

  count_step_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE2
    (adv && !match) |=> (count_value_reg == $past(count_value_reg) + 8'h01))
    else $error("count did not step by one");

  wrap_zero_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE3
    match |=> (count_value_reg == 8'h00))
    else $error("count did not wrap to zero on period match");

  post_flag_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE4
    last_match_s |=> post_evt_s)
    else $error("postscaled event or flag missing");

  irq_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE5
    o_irq |-> ($past(timer_irq_enable_reg) && $past(timer_irq_flag_reg)))
    else $error("interrupt raised without enable and flag");

  pre_bypass_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE6
    (prescale_select_reg == 3'h0 && tick && run_sync_reg && mode_reg == ptpi_pkg::MODE_SW_GATE) |-> adv)
    else $error("unity prescale skipped a timer clock");

  run_stage_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE7
    ($changed(run_sync_reg) && !$past(clk_src_reg)) |-> ($past(tick) && $past(run_s1_reg) == run_sync_reg))
    else $error("run level bypassed the second stage");

  flag_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE11
    (timer_irq_flag_reg && !flag_clr) |=> timer_irq_flag_reg)
    else $error("flag dropped without a clear");

  post_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE11
    o_postscaled_event |-> (post_cnt_reg == 4'h0))
    else $error("postscaler not back at zero");

  run_instr_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE8
    ($changed(run_sync_reg) && $past(clk_src_reg)) |-> ($past(tick) && $past(run_reg) == run_sync_reg))
    else $error("run level did not follow the instruction tick");

  ers_stage_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE7
    ($changed(ers_sync_reg) && !$past(clk_src_reg)) |-> ($past(tick) && $past(ers_s1_reg) == ers_sync_reg))
    else $error("external reset bypassed the second stage");

  post_step_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE4
    (match && post_cnt_reg != postscale_select_reg) |=> (post_cnt_reg == $past(post_cnt_reg) + 4'h1))
    else $error("postscaler did not advance on match");

  flag_win_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE4
    flag_set |=> timer_irq_flag_reg)
    else $error("flag not set by postscaled event");

  irq_on_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE5
    (timer_irq_flag_reg && timer_irq_enable_reg) |=> o_irq)
    else $error("enabled flag did not raise interrupt");

  irq_off_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE5
    !timer_irq_enable_reg |=> !o_irq)
    else $error("interrupt raised while disabled");

  stop_pre_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE2
    !run_sync_reg |=> $stable(pre_cnt_reg))
    else $error("prescaler moved while stopped");

  mode_pre_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n) // RULE1
    (mode_reg != ptpi_pkg::MODE_SW_GATE) |=> $stable(pre_cnt_reg))
    else $error("prescaler moved outside software gate mode");
endmodule : ptpi_timer

// ===== tb/ptpi_timer_tb.sv
// bench for the period timer: ahb-lite tasks, event interval and irq checks
// assumes: ptpi_pkg and ptpi_timer compiled first; hready tied to hreadyout
`timescale 1ns/10ps
module period_timer_postscale_irq_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic ers = 1'b0;
  logic [2:0] pin_div = 3'h0;
  logic hrdy;
  logic hresp;
  logic [31:0] hrdata;
  logic ev;
  logic irq;
  int cyc = 0;
  int n_mismatch = 0;
  int checks_done = 0;

  ptpi_timer dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
    .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy),
    .o_hresp(hresp), .o_hrdata(hrdata), .i_timer_clock_input(pin_div[2]), .i_ext_reset_signal(ers),
    .o_postscaled_event(ev), .o_irq(irq));

  initial begin
    forever #20 clk = ~clk;
  end

  // pin clock: four sys cycles high, four low, slow enough for the filter
  always @(posedge clk) begin
    pin_div <= pin_div + 3'h1;
    cyc <= cyc + 1;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : wrap_up

  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
  endtask : do_reset

  // waits as long as the slave stalls; only the watchdog ends a hung transfer
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do begin
      @(posedge clk);
    end while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do begin
      @(posedge clk);
    end while (hrdy !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(x, e);
  endtask : rd_chk

  function automatic logic [31:0] ctl(input logic run, input logic src, input logic [2:0] pre,
    input logic [3:0] post, input logic [4:0] mode);
    return (32'(run) << ptpi_pkg::CTRL_RUN_BIT) | (32'(src) << ptpi_pkg::CTRL_SRC_BIT) |
      (32'(pre) << ptpi_pkg::CTRL_PRE_LSB) | (32'(post) << ptpi_pkg::CTRL_POST_LSB) |
      (32'(mode) << ptpi_pkg::CTRL_MODE_LSB);
  endfunction : ctl

  task automatic wait_ev(output int t);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (ev !== 1'b1 && n < 5000);
    if (n >= 5000) begin
      chk(32'h0, 32'h1);
      wrap_up();
    end
    t = cyc;
  endtask : wait_ev

  // interval between steady events in sys cycles
  task automatic interval(input logic src, input logic [2:0] pre, input logic [3:0] post,
    input logic [7:0] per, input int unit);
    int t0;
    int t1;
    do_reset();
    wr(ptpi_pkg::OFS_PERIOD, {24'h0, per});
    wr(ptpi_pkg::OFS_CTRL, ctl(1'b1, src, pre, post, 5'h0));
    wait_ev(t0);
    wait_ev(t1);
    chk(32'(t1 - t0), 32'(unit * (2 ** pre) * (per + 1) * (post + 1)));
  endtask : interval

  // count must not move for the given control word
  task automatic hold(input logic [31:0] c);
    logic [31:0] a;
    logic [31:0] b;
    do_reset();
    wr(ptpi_pkg::OFS_CTRL, ctl(1'b1, 1'b1, 3'h0, 4'h0, 5'h0));
    repeat (100) @(posedge clk);
    rd_chk(ptpi_pkg::OFS_STATUS, 32'h2);
    wr(ptpi_pkg::OFS_CTRL, c);
    repeat (20) @(posedge clk);
    bus(1'b0, ptpi_pkg::OFS_COUNT, 32'h0, a);
    repeat (40) @(posedge clk);
    bus(1'b0, ptpi_pkg::OFS_COUNT, 32'h0, b);
    chk(b, a);
    chk(32'(a != 32'h0), 32'h1);
  endtask : hold

  initial begin
    int t;
    do_reset();
    rd_chk(ptpi_pkg::OFS_CTRL, 32'h0);
    rd_chk(ptpi_pkg::OFS_PERIOD, 32'hFF);
    rd_chk(ptpi_pkg::OFS_COUNT, 32'h0);
    rd_chk(ptpi_pkg::OFS_STATUS, 32'h0);
    rd_chk(ptpi_pkg::OFS_IRQ_EN, 32'h0);
    wr(8'h20, 32'hFFFFFFFF);
    rd_chk(8'h20, 32'h0);
    wr(ptpi_pkg::OFS_PERIOD, 32'h1A5);
    rd_chk(ptpi_pkg::OFS_PERIOD, 32'hA5);
    $display("test registers done");
    interval(1'b1, 3'h0, 4'h0, 8'h00, 4);
    interval(1'b1, 3'h0, 4'h0, 8'hFF, 4);
    interval(1'b1, 3'h1, 4'h3, 8'h02, 4);
    interval(1'b1, 3'h3, 4'hF, 8'h02, 4);
    interval(1'b0, 3'h0, 4'h0, 8'h05, 8);
    interval(1'b0, 3'h2, 4'h1, 8'h03, 8);
    $display("test intervals done");
    hold(ctl(1'b0, 1'b1, 3'h0, 4'h0, 5'h0));
    hold(ctl(1'b1, 1'b1, 3'h0, 4'h0, 5'h1));
    $display("test gating done");
    do_reset();
    wr(ptpi_pkg::OFS_IRQ_EN, 32'h1);
    wr(ptpi_pkg::OFS_PERIOD, 32'h0);
    wr(ptpi_pkg::OFS_CTRL, ctl(1'b1, 1'b1, 3'h0, 4'h0, 5'h0));
    wait_ev(t);
    repeat (3) @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(ptpi_pkg::OFS_CTRL, 32'h0);
    // stop now retimes on pin ticks: two of them, up to 16 cycles
    repeat (30) @(posedge clk);
    rd_chk(ptpi_pkg::OFS_STATUS, 32'h1);
    wr(ptpi_pkg::OFS_IRQ_EN, 32'h0);
    repeat (3) @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(ptpi_pkg::OFS_IRQ_EN, 32'h1);
    repeat (3) @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(ptpi_pkg::OFS_IRQ_CLR, 32'h1);
    repeat (3) @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    rd_chk(ptpi_pkg::OFS_STATUS, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    chk({31'h0, hrdy}, 32'h1);
    @(posedge clk);
    ers <= 1'b1;
    // pin filter plus two pin ticks, up to 20 cycles
    repeat (30) @(posedge clk);
    rd_chk(ptpi_pkg::OFS_STATUS, 32'h4);
    $display("test irq done");
    wrap_up();
  end

  // whole run is near 6600 cycles
  initial begin
    #(40 * 40000);
    n_mismatch++;
    wrap_up();
  end
endmodule : period_timer_postscale_irq_tb_top
